//--- nra_pkg.sv
// Package for the namespace reservation arbiter: encodings, register map, carriers
package nra_pkg;

    // Reservation kinds as carried in reservation_type_field (0 means none held)
    localparam logic [2:0] KIND_NONE = 3'h0;
    localparam logic [2:0] KIND_WE = 3'h1;
    localparam logic [2:0] KIND_EA = 3'h2;
    localparam logic [2:0] KIND_WE_RO = 3'h3;
    localparam logic [2:0] KIND_EA_RO = 3'h4;
    localparam logic [2:0] KIND_WE_AR = 3'h5;
    localparam logic [2:0] KIND_EA_AR = 3'h6;

    // Action field codes
    localparam logic [2:0] REG_ACT_REGISTER = 3'h0;
    localparam logic [2:0] REG_ACT_UNREGISTER = 3'h1;
    localparam logic [2:0] REG_ACT_REPLACE = 3'h2;
    localparam logic [2:0] ACQ_ACT_ACQUIRE = 3'h0;
    localparam logic [2:0] ACQ_ACT_PREEMPT = 3'h1;
    localparam logic [2:0] ACQ_ACT_PREEMPT_ABORT = 3'h2;
    localparam logic [2:0] REL_ACT_RELEASE = 3'h0;

    // Completion status codes
    localparam logic [1:0] ST_SUCCESS = 2'h0;
    localparam logic [1:0] ST_CONFLICT = 2'h1;
    localparam logic [1:0] ST_INVALID_FIELD = 2'h2;

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_HOLDER = 8'h08;
    localparam logic [7:0] OFS_REGMAP = 8'h0C;
    localparam logic [7:0] OFS_CONFLICTS = 8'h10;

    // Control register fields
    localparam int CTRL_PTPL_BIT = 0;
    localparam int CTRL_PWRLOSS_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Command classes presented to the arbiter
    typedef enum logic [2:0] {
        NRA_CLS_READ,
        NRA_CLS_WRITE,
        NRA_CLS_REGISTER,
        NRA_CLS_ACQUIRE,
        NRA_CLS_RELEASE,
        NRA_CLS_OTHER
    } nra_cls_t;

    // One command as seen by the arbiter
    typedef struct packed {
        nra_cls_t cls;
        logic [2:0] host;
        logic [2:0] action;
        logic [2:0] reservation_type_field;
        logic ignore_key;
        logic [63:0] cur_key;
        logic [63:0] new_key;
        logic ptpl_update;
        logic [1:0] ptpl_value;
    } nra_cmd_t;

    // Completion returned for one command
    typedef struct packed {
        logic [2:0] host;
        logic [1:0] status;
        logic execute;
    } nra_cpl_t;

endpackage : nra_pkg

//--- nra_arbiter.sv
// Namespace reservation arbiter: registrant table, reservation state and command rulings
`timescale 1ns/1ps

// Behaviour
// - Six reservation kinds: WE, EA, each plain, registrants-only, all-registrants.
// - Plain WE: only holder writes, all read; plain EA: holder only; one holder.
// - Registrants-only: registrants share holder rights; non-registrants limited by kind.
// - All-registrants: every registrant is a holder with full rights.
// - Reads allowed under WE kinds; under EA conflict for non-registrants, plain registrants.
// - Writes conflict for non-registrants; registrants conflict only under plain kinds.
// - Acquire by a non-holder conflicts while any reservation exists.
// - Release and preempt conflict for non-registrants, allowed for registrants.
// - Other commands are processed normally whatever the reservation state.
// - A conflicting command is aborted with Reservation Conflict status.
// - State survives resets; only power loss clears it, unless persistence set.
// - Per-namespace persistence state, set by register or set-features commands; here set by register commands or a CTRL register write.
// - Unregister action 001b; key mismatch or unregistered host gives conflict.
// - Ignore-key bit skips the current key comparison.
// - Unregister drops registration; sole or last holder releases the reservation.
// - Unregister releasing registrants-only kind notifies other registrants.
// - Acquire action 000b; key mismatch or unregistered host gives conflict.
// - One reservation per namespace; holder re-acquiring same kind succeeds.
// - Release action 000b with held kind and key; key mismatch gives conflict.
// - Holder release with kind different from current kind gives Invalid Field status.
// - Release with no reservation or by a registrant non-holder succeeds with no effect.
// - Release of non-plain kinds notifies all other registrants.
// - Register 000b with new key; replace 010b needs matching current key.
module nra_arbiter #(
    parameter int HOSTS = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input nra_pkg::nra_cmd_t cmd,
    output nra_pkg::nra_cpl_t cpl,
    output logic cpl_valid,
    output logic [HOSTS-1:0] notify_released,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    logic [HOSTS-1:0] reg_valid_q;
    logic [63:0] reg_key_q [HOSTS];
    logic res_valid_q;
    logic [2:0] res_type_q;
    logic [2:0] res_holder_q;
    logic ptpl_q;
    logic [31:0] conflicts_q;

    logic is_reg;
    logic is_holder;
    logic key_ok;
    logic all_reg_kind;
    logic plain_kind;
    logic ea_kind;
    logic [1:0] status;
    logic do_exec;
    logic pwr_loss;
    logic apb_wr;

    function automatic logic kind_all_reg(input logic [2:0] t);
        return t == nra_pkg::KIND_WE_AR || t == nra_pkg::KIND_EA_AR;
    endfunction : kind_all_reg

    function automatic logic kind_valid(input logic [2:0] t);
        return t >= nra_pkg::KIND_WE && t <= nra_pkg::KIND_EA_AR;
    endfunction : kind_valid

    assign is_reg = reg_valid_q[cmd.host];
    assign all_reg_kind = kind_all_reg(res_type_q);
    assign plain_kind = res_type_q == nra_pkg::KIND_WE || res_type_q == nra_pkg::KIND_EA;
    assign ea_kind = res_type_q == nra_pkg::KIND_EA || res_type_q == nra_pkg::KIND_EA_RO
        || res_type_q == nra_pkg::KIND_EA_AR;
    // Every registrant holds an all-registrants kind
    assign is_holder = res_valid_q && is_reg && (all_reg_kind || res_holder_q == cmd.host);
    assign key_ok = cmd.ignore_key || reg_key_q[cmd.host] == cmd.cur_key;
    // Only the access edge with ready high may write, so a held access cannot repeat it
    assign apb_wr = psel && penable && pwrite && pready;
    assign pwr_loss = apb_wr && paddr == nra_pkg::OFS_CTRL && pwdata[nra_pkg::CTRL_PWRLOSS_BIT];

    // Ruling for the presented command
    always_comb begin
        status = nra_pkg::ST_SUCCESS;
        do_exec = 1'b1;
        case (cmd.cls)
            nra_pkg::NRA_CLS_READ: begin
                if (res_valid_q && !is_holder && ea_kind && (!is_reg || plain_kind)) begin
                    status = nra_pkg::ST_CONFLICT;
                end
            end
            nra_pkg::NRA_CLS_WRITE: begin
                if (res_valid_q && !is_holder && (!is_reg || plain_kind)) begin
                    status = nra_pkg::ST_CONFLICT;
                end
            end
            nra_pkg::NRA_CLS_REGISTER: begin
                if (cmd.action == nra_pkg::REG_ACT_UNREGISTER) begin
                    if (!is_reg || !key_ok) begin
                        status = nra_pkg::ST_CONFLICT;
                    end
                end else if (cmd.action == nra_pkg::REG_ACT_REGISTER) begin
                    if (is_reg && reg_key_q[cmd.host] != cmd.new_key) begin
                        status = nra_pkg::ST_CONFLICT;
                    end
                end else if (cmd.action == nra_pkg::REG_ACT_REPLACE) begin
                    if (!cmd.ignore_key && (!is_reg || !key_ok)) begin
                        status = nra_pkg::ST_CONFLICT;
                    end
                end else begin
                    status = nra_pkg::ST_INVALID_FIELD;
                end
            end
            nra_pkg::NRA_CLS_ACQUIRE: begin
                if (cmd.action == nra_pkg::ACQ_ACT_ACQUIRE) begin
                    if (!is_reg || !key_ok) begin
                        status = nra_pkg::ST_CONFLICT;
                    end else if (res_valid_q && !is_holder) begin
                        status = nra_pkg::ST_CONFLICT;
                    end else if (res_valid_q && res_type_q != cmd.reservation_type_field) begin
                        status = nra_pkg::ST_CONFLICT;
                    end else if (!kind_valid(cmd.reservation_type_field)) begin
                        status = nra_pkg::ST_INVALID_FIELD;
                    end
                end else begin
                    // Preempt only gated by registration here
                    if (!is_reg) begin
                        status = nra_pkg::ST_CONFLICT;
                    end
                end
            end
            nra_pkg::NRA_CLS_RELEASE: begin
                if (!is_reg || !key_ok) begin
                    status = nra_pkg::ST_CONFLICT;
                end else if (is_holder && res_type_q != cmd.reservation_type_field) begin
                    status = nra_pkg::ST_INVALID_FIELD;
                end
            end
            default: begin
                status = nra_pkg::ST_SUCCESS;
            end
        endcase
        if (status != nra_pkg::ST_SUCCESS) begin
            do_exec = 1'b0;
        end
    end

    // Registrant table; only power loss may clear it
    always_ff @(posedge clk) begin
        if (pwr_loss && !ptpl_q) begin
            reg_valid_q <= '0;
        end else if (cmd_valid && do_exec && cmd.cls == nra_pkg::NRA_CLS_REGISTER) begin
            if (cmd.action == nra_pkg::REG_ACT_UNREGISTER) begin
                reg_valid_q[cmd.host] <= 1'b0;
            end else begin
                reg_valid_q[cmd.host] <= 1'b1;
                reg_key_q[cmd.host] <= cmd.new_key;
            end
        end
    end

    // Reservation state, also held across resets
    always_ff @(posedge clk) begin
        if (pwr_loss && !ptpl_q) begin
            res_valid_q <= 1'b0;
            res_type_q <= nra_pkg::KIND_NONE;
        end else if (cmd_valid && do_exec) begin
            if (cmd.cls == nra_pkg::NRA_CLS_ACQUIRE && cmd.action == nra_pkg::ACQ_ACT_ACQUIRE) begin
                res_valid_q <= 1'b1;
                res_type_q <= cmd.reservation_type_field;
                res_holder_q <= cmd.host;
            end else if (cmd.cls == nra_pkg::NRA_CLS_RELEASE && is_holder
                && cmd.action == nra_pkg::REL_ACT_RELEASE) begin
                res_valid_q <= 1'b0;
                res_type_q <= nra_pkg::KIND_NONE;
            end else if (cmd.cls == nra_pkg::NRA_CLS_REGISTER && is_holder
                && cmd.action == nra_pkg::REG_ACT_UNREGISTER
                && (!all_reg_kind || reg_valid_q == (HOSTS'(1) << cmd.host))) begin
                res_valid_q <= 1'b0;
                res_type_q <= nra_pkg::KIND_NONE;
            end
        end
    end

    // Persistence state
    always_ff @(posedge clk) begin
        if (reset) begin
            ptpl_q <= ptpl_q;
        end else if (apb_wr && paddr == nra_pkg::OFS_CTRL) begin
            ptpl_q <= pwdata[nra_pkg::CTRL_PTPL_BIT];
        end else if (cmd_valid && do_exec && cmd.cls == nra_pkg::NRA_CLS_REGISTER
            && cmd.ptpl_update) begin
            ptpl_q <= cmd.ptpl_value[0];
        end
    end

    // Completion and notifications
    always_ff @(posedge clk) begin
        if (reset) begin
            cpl_valid <= 1'b0;
            cpl <= '0;
            notify_released <= '0;
            conflicts_q <= '0;
        end else begin
            cpl_valid <= cmd_valid;
            cpl.host <= cmd.host;
            cpl.status <= status;
            cpl.execute <= cmd_valid && do_exec;
            notify_released <= '0;
            if (cmd_valid && status == nra_pkg::ST_CONFLICT) begin
                conflicts_q <= conflicts_q + 32'h1;
            end
            if (cmd_valid && do_exec && is_holder) begin
                // Release of shared kinds notifies others
                if (cmd.cls == nra_pkg::NRA_CLS_RELEASE && !plain_kind
                    && cmd.action == nra_pkg::REL_ACT_RELEASE) begin
                    notify_released <= reg_valid_q & ~(HOSTS'(1) << cmd.host);
                end
                // Unregister of registrants-only kind notifies others
                if (cmd.cls == nra_pkg::NRA_CLS_REGISTER
                    && cmd.action == nra_pkg::REG_ACT_UNREGISTER
                    && (res_type_q == nra_pkg::KIND_WE_RO
                    || res_type_q == nra_pkg::KIND_EA_RO)) begin
                    notify_released <= reg_valid_q & ~(HOSTS'(1) << cmd.host);
                end
            end
        end
    end

    // APB slave, zero wait states
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable) begin
                case (paddr)
                    nra_pkg::OFS_CTRL: prdata <= {31'h0, ptpl_q};
                    nra_pkg::OFS_STATUS: prdata <= {28'h0, res_type_q, res_valid_q};
                    nra_pkg::OFS_HOLDER: prdata <= {29'h0, res_holder_q};
                    nra_pkg::OFS_REGMAP: prdata <= 32'(reg_valid_q);
                    nra_pkg::OFS_CONFLICTS: prdata <= conflicts_q;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule : nra_arbiter

//--- nra_arbiter_assertions.sv
// Checker for the reservation arbiter completion, notification and APB ports
`timescale 1ns/1ps
module nra_arbiter_checker #(
    parameter int HOSTS = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input nra_pkg::nra_cmd_t cmd,
    input nra_pkg::nra_cpl_t cpl,
    input wire logic cpl_valid,
    input wire logic [HOSTS-1:0] notify_released,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_cpl_one_cycle: assert property (cmd_valid |=> cpl_valid && cpl.host == $past(cmd.host))
        else $error("completion missing one cycle after command");
    a_no_stray_cpl: assert property (!cmd_valid |=> !cpl_valid)
        else $error("completion without a command");
    a_conflict_aborts: assert property (cpl_valid |-> cpl.execute == (cpl.status == 2'h0))
        else $error("execute flag disagrees with status");
    a_other_allowed: assert property (cmd_valid && cmd.cls == nra_pkg::NRA_CLS_OTHER |=>
        cpl.status == nra_pkg::ST_SUCCESS && cpl.execute)
        else $error("unrelated command not processed");
    a_rw_no_invalid: assert property (cmd_valid && cmd.cls inside {nra_pkg::NRA_CLS_READ,
        nra_pkg::NRA_CLS_WRITE} |=> cpl.status != nra_pkg::ST_INVALID_FIELD)
        else $error("read or write given invalid field");
    a_notify_issuer: assert property (notify_released != '0 |-> cpl_valid
        && !notify_released[cpl.host])
        else $error("notification out of step or sent to issuer");
    a_notify_cause: assert property (notify_released != '0 |-> $past(cmd.cls) inside
        {nra_pkg::NRA_CLS_REGISTER, nra_pkg::NRA_CLS_RELEASE} && cpl.status == 2'h0)
        else $error("notification from wrong command");
    a_apb_wait: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h10 |-> pslverr)
        else $error("unmapped access without error");
endmodule : nra_arbiter_checker

bind nra_arbiter nra_arbiter_checker #(.HOSTS(HOSTS)) u_chk (.clk(clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .cpl(cpl), .cpl_valid(cpl_valid),
    .notify_released(notify_released), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr));

//--- nra_host_model.sv
// Host model: issues one arbiter command and collects its completion
`timescale 1ns/1ps
module nra_host_model #(
    parameter int HOSTS = 8
) (
    input wire logic clk,
    output logic cmd_valid,
    output nra_pkg::nra_cmd_t cmd,
    input nra_pkg::nra_cpl_t cpl,
    input wire logic cpl_valid,
    input wire logic [HOSTS-1:0] notify_released
);
    initial cmd_valid = 1'b0;
    initial cmd = '0;
    // action code and keys carried as given
    task automatic send(input nra_pkg::nra_cmd_t c, output nra_pkg::nra_cpl_t r,
        output logic [HOSTS-1:0] n, output bit ok);
        ok = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Released fields show a changed pattern so stale values cannot pass
        cmd <= nra_pkg::nra_cmd_t'(~c);
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = cpl_valid === 1'b1;
            r = cpl;
            n = notify_released;
        end
    endtask : send
endmodule : nra_host_model

//--- test_namespace_reservation_arbiter.sv
// Testbench for the namespace reservation arbiter
`timescale 1ns/1ps
module test_namespace_reservation_arbiter;
    localparam logic [1:0] OK = nra_pkg::ST_SUCCESS;
    localparam logic [1:0] CF = nra_pkg::ST_CONFLICT;
    localparam nra_pkg::nra_cls_t RD = nra_pkg::NRA_CLS_READ;
    localparam nra_pkg::nra_cls_t WR = nra_pkg::NRA_CLS_WRITE;
    localparam nra_pkg::nra_cls_t RG = nra_pkg::NRA_CLS_REGISTER;
    localparam nra_pkg::nra_cls_t AQ = nra_pkg::NRA_CLS_ACQUIRE;
    localparam nra_pkg::nra_cls_t RL = nra_pkg::NRA_CLS_RELEASE;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, cmd_valid, cpl_valid;
    logic [7:0] notify_released;
    nra_pkg::nra_cmd_t cmd;
    nra_pkg::nra_cpl_t cpl;
    int failures = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    nra_arbiter #(.HOSTS(8)) dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
        .cpl(cpl), .cpl_valid(cpl_valid), .notify_released(notify_released), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    nra_host_model #(.HOSTS(8)) host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .cpl(cpl),
        .cpl_valid(cpl_valid), .notify_released(notify_released));
    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        bit got = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 8 && !got; i++) begin
            @(posedge clk);
            got = pready === 1'b1;
            q = prdata;
            e = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!got) begin
            failures++;
            end_sim();
        end
    endtask : apb
    // Persistence cleared first so the power-loss write always empties the table
    task automatic power_loss;
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h2);
    endtask : power_loss
    function automatic logic [63:0] key(input int h);
        return 64'h5A00 + 64'(h);
    endfunction : key
    task automatic cx(input nra_pkg::nra_cls_t c, input int h, input int act, input int t,
        input logic [63:0] k, input logic [1:0] st, input logic [7:0] nt = 8'h00,
        input bit pu = 1'b0);
        nra_pkg::nra_cmd_t m = '0;
        nra_pkg::nra_cpl_t r;
        logic [7:0] n;
        bit ok;
        m.cls = c;
        m.host = 3'(h);
        m.action = 3'(act);
        m.reservation_type_field = 3'(t);
        m.ignore_key = k == key(7);
        m.cur_key = k;
        m.new_key = k;
        m.ptpl_update = pu;
        m.ptpl_value = {1'b0, pu};
        host.send(m, r, n, ok);
        check("completion", 32'(ok), 32'h1);
        if (!ok) end_sim();
        check("status", 32'(r.status), 32'(st));
        check("execute", 32'(r.execute), 32'(st == OK));
        check("notify", 32'(n), 32'(nt));
    endtask : cx
    // Hosts 0..2 are registrants, host 0 holds, all-registrant kinds share holding
    function automatic logic [1:0] rw_st(bit wr, int t, int h);
        bit rg = h < 3;
        bit hd = h == 0 || (t > 4 && rg);
        if (hd || (wr ? rg && t > 2 : !(t == 2 || (!rg && t > 3 && t % 2 == 0)))) return OK;
        return CF;
    endfunction : rw_st
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        power_loss();
        for (int h = 0; h < 3; h++) cx(RG, h, 0, 0, key(h), OK);
        cx(RG, 2, 2, 0, key(6), CF);
        apb(1'b0, 8'h0C, 32'h0);
        check("regmap", q, 32'h7);
        for (int t = 1; t < 7; t++) begin
            cx(AQ, 0, 0, t, t % 2 ? key(7) : key(0), OK);
            for (int i = 0; i < 6; i++) cx(i % 2 ? WR : RD, i < 2 ? 0 : i < 4 ? 1 : 5, 0, 0,
                key(0), rw_st(i % 2, t, i < 2 ? 0 : i < 4 ? 1 : 5));
            cx(nra_pkg::NRA_CLS_OTHER, 5, 0, 0, key(5), OK);
            cx(AQ, 5, 0, t, key(5), CF);
            cx(AQ, 0, 0, t == 1 ? 2 : 1, key(0), CF);
            cx(AQ, 0, 0, t, key(0), OK);
            if (t < 5) cx(AQ, 1, 0, t, key(1), CF);
            if (t < 5) cx(RL, 1, 0, t, key(1), OK);
            cx(RL, 5, 0, t, key(5), CF);
            cx(RL, 0, 0, t, key(6), CF);
            cx(RL, 0, 0, t == 1 ? 2 : 1, key(0), nra_pkg::ST_INVALID_FIELD);
            cx(RL, 0, 0, t, key(0), OK, t > 2 ? 8'h06 : 8'h00);
            cx(WR, 5, 0, 0, key(5), OK);
        end
        cx(AQ, 0, 0, 3, key(0), OK);
        cx(RG, 1, 1, 0, key(6), CF);
        cx(RG, 5, 1, 0, key(5), CF);
        cx(RG, 0, 1, 0, key(7), OK, 8'h06);
        cx(WR, 5, 0, 0, key(5), OK);
        apb(1'b0, 8'h0C, 32'h0);
        check("regmap", q, 32'h6);
        cx(AQ, 1, 0, 2, key(1), OK);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        cx(RD, 5, 0, 0, key(5), CF);
        apb(1'b0, nra_pkg::OFS_STATUS, 32'h0);
        check("status reg", q, 32'h5);
        apb(1'b0, nra_pkg::OFS_HOLDER, 32'h0);
        check("holder", q, 32'h1);
        apb(1'b0, nra_pkg::OFS_CONFLICTS, 32'h0);
        check("conflicts", q, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        check("persist", {31'h0, q[0]}, 32'h1);
        cx(RD, 5, 0, 0, key(5), CF);
        power_loss();
        cx(RD, 5, 0, 0, key(5), OK);
        apb(1'b0, 8'h0C, 32'h0);
        check("regmap", q, 32'h0);
        cx(RG, 3, 0, 0, key(3), OK, 8'h00, 1'b1);
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b0, 8'h0C, 32'h0);
        check("regmap", q, 32'h8);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", {31'h0, e}, 32'h1);
        end_sim();
    end
endmodule : test_namespace_reservation_arbiter
